// ---- core/svwmr_top.sv ----
// Supervisor that drives a processor reset from supply, manual reset and
// watchdog causes. Assumes all inputs are synchronous to clk and that rst
// is the power-on reset of the internal time base.
//
// Notes on behaviour
// - open-drain output pulls low only during reset.
// - low manual reset input asserts reset.
// - manual release still holds full reset timeout.
// - short low pulses on manual input ignored.
// - open manual input reads high, no reset.
// - no watchdog edge within timeout asserts reset.
// - any watchdog edge or reset clears timer.
// - watchdog timer held zero throughout reset.
// - floating watchdog input self-clears at seven-eighths period.
// - short supply dips below threshold are filtered.
// - low supply asserts reset, then timeout after recovery.
// - watchdog-caused reset also lasts full timeout.
// - timeout expiry releases reset, restarts watchdog.
// - four build-time reset and watchdog periods.
`timescale 1ns/1ps
`include "svwmr_cfg.svh"

module svwmr_top #(
    parameter logic [1:0]  RP_SEL   = `SVWMR_RP_SEL_DEF,
    parameter logic [1:0]  WD_SEL   = `SVWMR_WD_SEL_DEF,
    parameter logic [31:0] RP_CYC_A = `SVWMR_RP_A_CYC,
    parameter logic [31:0] RP_CYC_B = `SVWMR_RP_B_CYC,
    parameter logic [31:0] RP_CYC_C = `SVWMR_RP_C_CYC,
    parameter logic [31:0] RP_CYC_D = `SVWMR_RP_D_CYC,
    parameter logic [31:0] WD_CYC_W = `SVWMR_WD_W_CYC,
    parameter logic [31:0] WD_CYC_X = `SVWMR_WD_X_CYC,
    parameter logic [31:0] WD_CYC_Y = `SVWMR_WD_Y_CYC,
    parameter logic [31:0] WD_CYC_Z = `SVWMR_WD_Z_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic supply_below_threshold,
    input  wire logic manual_reset_n,
    input  wire logic watchdog_input,
    input  wire logic watchdog_input_driven,
    output logic      reset_out,
    output logic      reset_out_n,
    output logic      reset_od_out,
    output logic      reset_od_oe_n
);

    // ======================================================================
    // Period selection
    // ======================================================================
    wire logic [31:0] rp_lim =
        (RP_SEL == 2'h0) ? RP_CYC_A :
        (RP_SEL == 2'h1) ? RP_CYC_B :
        (RP_SEL == 2'h2) ? RP_CYC_C : RP_CYC_D;
    wire logic [31:0] wd_lim =
        (WD_SEL == 2'h0) ? WD_CYC_W :
        (WD_SEL == 2'h1) ? WD_CYC_X :
        (WD_SEL == 2'h2) ? WD_CYC_Y : WD_CYC_Z;
    // Seven-eighths of the watchdog period, for the self-service path.
    wire logic [31:0] wd_auto_lim = (wd_lim >> 3) * 32'h0000_0007;

    // ======================================================================
    // Input filtering
    // ======================================================================
    // The manual input is active low; a floating pin is modelled as high by
    // the pad pull-up, so the core only ever sees an inactive level.
    wire logic mr_raw = !manual_reset_n;
    logic      mr_flt;
    logic      sup_flt;

    svwmr_glitch_filter #(
        .LIMIT (`SVWMR_MR_GLITCH_CYC)
    ) u_mr_filter (
        .clk        (clk),
        .rst        (rst),
        .in_active  (mr_raw),
        .out_active (mr_flt)
    );

    // The longer dip window is used; it also covers the shorter
    // full-amplitude glitch.
    svwmr_glitch_filter #(
        .LIMIT (`SVWMR_SUP_GLITCH_CYC)
    ) u_sup_filter (
        .clk        (clk),
        .rst        (rst),
        .in_active  (supply_below_threshold),
        .out_active (sup_flt)
    );

    // ======================================================================
    // Watchdog edge detection
    // ======================================================================
    // Every pulse lasting one clock or more is seen, well inside the
    // shortest pulse that must be caught.
    logic      wdi_prev_ff;
    wire logic wd_edge = watchdog_input_driven
                         && (watchdog_input != wdi_prev_ff);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdi_prev_ff <= 1'b0;
        end else begin
            wdi_prev_ff <= watchdog_input;
        end
    end

    // ======================================================================
    // Sequencer and counters
    // ======================================================================
    svwmr_pkg::svwmr_state_t state_ff;
    svwmr_pkg::svwmr_state_t nxt_state;
    svwmr_pkg::svwmr_cause_t cause;
    logic [31:0]             rp_cnt_ff;
    logic [31:0]             nxt_rp_cnt;
    logic [31:0]             wd_cnt_ff;
    logic [31:0]             nxt_wd_cnt;

    wire logic in_hold   = (state_ff == svwmr_pkg::SVWMR_HOLD);
    // A driver that lets go late in a period leaves the timer past the
    // self-service point, so that point is a threshold and expiry needs a driver.
    wire logic wd_expire = !in_hold && !wd_edge && watchdog_input_driven
                           && (wd_cnt_ff == wd_lim - 32'h0000_0001);
    wire logic wd_auto   = !watchdog_input_driven
                           && (wd_cnt_ff >= wd_auto_lim - 32'h0000_0001);
    wire logic rp_done   = (rp_cnt_ff == rp_lim - 32'h0000_0001);

    assign cause.manual   = mr_flt;
    assign cause.supply   = sup_flt;
    assign cause.watchdog = wd_expire;
    wire logic level_cause = cause.manual || cause.supply;
    wire logic any_cause   = level_cause || cause.watchdog;

    // Power-on enters the hold state, so the processor sees a full
    // timeout after the time base comes up, like a supply recovery.
    always_comb begin
        nxt_state  = state_ff;
        nxt_rp_cnt = rp_cnt_ff;
        unique case (state_ff)
            svwmr_pkg::SVWMR_HOLD: begin
                if (level_cause) begin
                    nxt_rp_cnt = 32'h0000_0000;
                end else if (rp_done) begin
                    nxt_state  = svwmr_pkg::SVWMR_RUN;
                    nxt_rp_cnt = 32'h0000_0000;
                end else begin
                    nxt_rp_cnt = rp_cnt_ff + 32'h0000_0001;
                end
            end
            svwmr_pkg::SVWMR_RUN: begin
                if (any_cause) begin
                    nxt_state  = svwmr_pkg::SVWMR_HOLD;
                    nxt_rp_cnt = 32'h0000_0000;
                end
            end
            default: begin
                nxt_state  = svwmr_pkg::SVWMR_HOLD;
                nxt_rp_cnt = 32'h0000_0000;
            end
        endcase
    end

    wire logic nxt_hold = (nxt_state == svwmr_pkg::SVWMR_HOLD);

    always_comb begin
        if (nxt_hold || in_hold) begin
            nxt_wd_cnt = 32'h0000_0000;
        end else if (wd_edge || wd_auto) begin
            nxt_wd_cnt = 32'h0000_0000;
        end else begin
            nxt_wd_cnt = wd_cnt_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff  <= svwmr_pkg::SVWMR_HOLD;
            rp_cnt_ff <= 32'h0000_0000;
            wd_cnt_ff <= 32'h0000_0000;
        end else begin
            state_ff  <= nxt_state;
            rp_cnt_ff <= nxt_rp_cnt;
            wd_cnt_ff <= nxt_wd_cnt;
        end
    end

    // ======================================================================
    // Output stages
    // ======================================================================
    logic reset_ff;
    logic reset_n_ff;
    logic od_oe_n_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reset_ff   <= 1'b1;
            reset_n_ff <= 1'b0;
            od_oe_n_ff <= 1'b0;
        end else begin
            reset_ff   <= nxt_hold;
            reset_n_ff <= !nxt_hold;
            od_oe_n_ff <= !nxt_hold;
        end
    end

    assign reset_out     = reset_ff;
    assign reset_out_n   = reset_n_ff;
    // The open-drain stage only ever sinks; the pull-up sets the high.
    assign reset_od_out  = 1'b0;
    assign reset_od_oe_n = od_oe_n_ff;

    // ======================================================================
    // Checks
    // ======================================================================
    chk_od_drive_low: assert property (
        @(posedge clk) disable iff (rst)
        (reset_od_oe_n == reset_out) |-> 1'b0)
        else $error("open-drain enable disagrees with reset");

    chk_mr_asserts: assert property (
        @(posedge clk) disable iff (rst)
        mr_flt |=> reset_out)
        else $error("filtered manual reset did not assert reset");

    chk_mr_release_hold: assert property (
        @(posedge clk) disable iff (rst)
        $fell(mr_flt) && !sup_flt |-> reset_out [*3])
        else $error("reset dropped right after manual release");

    chk_mr_glitch_rej: assert property (
        @(posedge clk) disable iff (rst)
        (manual_reset_n ##1 !manual_reset_n ##1 manual_reset_n)
        |-> ##1 !mr_flt)
        else $error("one-cycle manual pulse passed the filter");

    chk_wd_timeout: assert property (
        @(posedge clk) disable iff (rst)
        wd_expire |=> reset_out && (wd_cnt_ff == 32'h0000_0000))
        else $error("watchdog expiry did not assert reset");

    chk_wd_edge_clear: assert property (
        @(posedge clk) disable iff (rst)
        wd_edge |=> (wd_cnt_ff == 32'h0000_0000))
        else $error("watchdog edge did not clear the timer");

    chk_wd_held_zero: assert property (
        @(posedge clk) disable iff (rst)
        reset_out |-> (wd_cnt_ff == 32'h0000_0000))
        else $error("watchdog timer ran during reset");

    chk_wd_float_safe: assert property (
        @(posedge clk) disable iff (rst)
        !watchdog_input_driven && !$past(watchdog_input_driven) && !reset_out
        |-> (wd_cnt_ff < wd_auto_lim))
        else $error("floating watchdog input let the timer pass 7/8");

    chk_sup_glitch_rej: assert property (
        @(posedge clk) disable iff (rst)
        (!supply_below_threshold ##1 supply_below_threshold
         ##1 !supply_below_threshold) |-> ##1 !sup_flt)
        else $error("short supply dip passed the filter");

    chk_sup_asserts: assert property (
        @(posedge clk) disable iff (rst)
        sup_flt |=> reset_out)
        else $error("low supply did not assert reset");

    chk_release_full: assert property (
        @(posedge clk) disable iff (rst)
        $fell(reset_out) |-> $past(rp_cnt_ff) == rp_lim - 32'h0000_0001)
        else $error("reset released before the full timeout");

    chk_release_restart: assert property (
        @(posedge clk) disable iff (rst)
        $fell(reset_out) |-> (wd_cnt_ff == 32'h0000_0000) ##1
        (wd_cnt_ff <= 32'h0000_0001))
        else $error("watchdog did not restart from zero at release");

    chk_cause_restart: assert property (
        @(posedge clk) disable iff (rst)
        in_hold && level_cause |=> reset_out && (rp_cnt_ff == 32'h0000_0000))
        else $error("active cause did not restart the reset timeout");

    chk_wd_counts_up: assert property (
        @(posedge clk) disable iff (rst)
        !in_hold && !nxt_hold && !wd_edge && !wd_auto
        |=> (wd_cnt_ff == $past(wd_cnt_ff) + 32'h0000_0001))
        else $error("watchdog timer did not count after release");

    chk_rp_count_up: assert property (
        @(posedge clk) disable iff (rst)
        in_hold && !level_cause && !rp_done
        |=> reset_out && (rp_cnt_ff == $past(rp_cnt_ff) + 32'h0000_0001))
        else $error("reset timeout did not advance while held");

    // Twelve low samples are one more than the manual filter needs.
    chk_mr_long_pass: assert property (
        @(posedge clk) disable iff (rst)
        (!manual_reset_n [*8] ##1 !manual_reset_n [*4]) |-> mr_flt)
        else $error("long manual reset was filtered away");

endmodule

// ---- core/svwmr_cfg.svh ----
// Constants of the supply, manual-reset and watchdog supervisor.
// Assumes a single 100 MHz clock; times are kept in their own unit and
// the cycle counts are derived from them here.
`ifndef SVWMR_CFG_SVH
`define SVWMR_CFG_SVH

// ==========================================================================
// Clock
// ==========================================================================
`define SVWMR_CLK_PERIOD_NS 10
`define SVWMR_NS_PER_US     1000

// ==========================================================================
// Reset timeout periods, minimum figures, in microseconds
// ==========================================================================
`define SVWMR_RP_A_US 64'd1000
`define SVWMR_RP_B_US 64'd20000
`define SVWMR_RP_C_US 64'd140000
`define SVWMR_RP_D_US 64'd1120000

// ==========================================================================
// Watchdog timeout periods, typical figures, in microseconds
// ==========================================================================
`define SVWMR_WD_W_US 64'd6300
`define SVWMR_WD_X_US 64'd102000
`define SVWMR_WD_Y_US 64'd1600000
`define SVWMR_WD_Z_US 64'd25600000

// Whole-cycle count of a time given in microseconds (exact at this rate).
`define SVWMR_US_TO_CYC(us) \
    (32'((us) * `SVWMR_NS_PER_US / `SVWMR_CLK_PERIOD_NS))

`define SVWMR_RP_A_CYC `SVWMR_US_TO_CYC(`SVWMR_RP_A_US)
`define SVWMR_RP_B_CYC `SVWMR_US_TO_CYC(`SVWMR_RP_B_US)
`define SVWMR_RP_C_CYC `SVWMR_US_TO_CYC(`SVWMR_RP_C_US)
`define SVWMR_RP_D_CYC `SVWMR_US_TO_CYC(`SVWMR_RP_D_US)
`define SVWMR_WD_W_CYC `SVWMR_US_TO_CYC(`SVWMR_WD_W_US)
`define SVWMR_WD_X_CYC `SVWMR_US_TO_CYC(`SVWMR_WD_X_US)
`define SVWMR_WD_Y_CYC `SVWMR_US_TO_CYC(`SVWMR_WD_Y_US)
`define SVWMR_WD_Z_CYC `SVWMR_US_TO_CYC(`SVWMR_WD_Z_US)

// ==========================================================================
// Glitch rejection, in nanoseconds; least times round up to whole cycles
// ==========================================================================
`define SVWMR_MR_GLITCH_NS  100
`define SVWMR_SUP_GLITCH_NS 4000
`define SVWMR_MR_GLITCH_CYC \
    (16'((`SVWMR_MR_GLITCH_NS + `SVWMR_CLK_PERIOD_NS - 1) / `SVWMR_CLK_PERIOD_NS))
`define SVWMR_SUP_GLITCH_CYC \
    (16'((`SVWMR_SUP_GLITCH_NS + `SVWMR_CLK_PERIOD_NS - 1) / `SVWMR_CLK_PERIOD_NS))

// Default choices: reset timeout C, watchdog timeout Y.
`define SVWMR_RP_SEL_DEF 2'h2
`define SVWMR_WD_SEL_DEF 2'h2

`endif

// ---- core/svwmr_pkg.sv ----
// Types shared by the supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package svwmr_pkg;

    // ======================================================================
    // Reset causes after filtering
    // ======================================================================
    typedef struct packed {
        logic manual;
        logic supply;
        logic watchdog;
    } svwmr_cause_t;

    // ======================================================================
    // Reset sequencer states, one-hot
    // ======================================================================
    typedef enum logic [1:0] {
        SVWMR_HOLD = 2'h1,
        SVWMR_RUN  = 2'h2
    } svwmr_state_t;

endpackage

// ---- core/svwmr_glitch_filter.sv ----
// Rejects short active pulses on a synchronous level input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps

module svwmr_glitch_filter #(
    parameter logic [15:0] LIMIT = 16'h000A
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic in_active,
    output logic      out_active
);

    logic [15:0] cnt_ff;
    logic        out_ff;
    wire  logic  reached = (cnt_ff == LIMIT);

    // ======================================================================
    // Output asserts on the (LIMIT+1)th consecutive active sample and
    // drops on the first inactive one; release is not filtered because
    // the reset timeout that follows already stretches it.
    // ======================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 16'h0000;
            out_ff <= 1'b0;
        end else if (!in_active) begin
            cnt_ff <= 16'h0000;
            out_ff <= 1'b0;
        end else if (reached) begin
            out_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    assign out_active = out_ff;

endmodule

// ---- verif/svwmr_cpu_model.sv ----
// Processor model on the far side: services the watchdog input and
// sits in reset while the open-drain reset line is low.
// Assumes the bench resolves the reset wire and drives mode at clk fall.
`timescale 1ns/1ps

module svwmr_cpu_model (
    input  wire logic        clk,
    input  wire logic        reset_line,
    input  wire logic [1:0]  mode,
    input  wire logic [15:0] period,
    output logic             watchdog_input,
    output logic             watchdog_input_driven
);
    // ======================================================================
    // Service loop
    // ======================================================================
    // Modes: 0 stalled, 1 level change per pass, 2 one-cycle pulse, 3 released.
    logic [15:0] loop_cnt = 16'h0000;

    initial watchdog_input = 1'b0;
    initial watchdog_input_driven = 1'b0;

    always @(negedge clk) begin
        if (reset_line !== 1'b1 || mode == 2'h3) begin
            // A released pin does not keep its last level, so show a moving one.
            loop_cnt <= 16'h0000;
            watchdog_input_driven <= 1'b0;
            watchdog_input <= ~watchdog_input;
        end else begin
            watchdog_input_driven <= 1'b1;
            loop_cnt <= (loop_cnt + 16'h0001 >= period) ? 16'h0000 : loop_cnt + 16'h0001;
            if (mode == 2'h1 && loop_cnt == 16'h0000) begin
                watchdog_input <= ~watchdog_input;
            end else if (mode == 2'h2) begin
                watchdog_input <= (loop_cnt == 16'h0000);
            end
        end
    end
endmodule

// ---- verif/tb_supervisor_watchdog_manual_reset.sv ----
// Self-checking bench of the supervisor with shortened timeouts.
// Assumes the design files and the processor model are compiled first.
`timescale 1ns/1ps

module tb_supervisor_watchdog_manual_reset;
    // ======================================================================
    // Set-up
    // ======================================================================
    localparam int RP = 40;
    localparam int WD = 200;

    logic        clk;
    logic        rst;
    logic        supply_below_threshold;
    logic        manual_reset_n;
    logic        watchdog_input;
    logic        watchdog_input_driven;
    logic        reset_out;
    logic        reset_out_n;
    logic        reset_od_out;
    logic        reset_od_oe_n;
    logic        reset_line;
    logic [1:0]  cpu_mode;
    logic [15:0] cpu_period;
    int          err_count;
    int          total_checks;

    // The open-drain wire has a pull-up, so a released line reads high.
    assign reset_line = reset_od_oe_n ? 1'b1 : reset_od_out;

    svwmr_top #(
        .RP_CYC_C (32'h00000028),
        .WD_CYC_Y (32'h000000C8)
    ) DUT (
        .clk                    (clk),
        .rst                    (rst),
        .supply_below_threshold (supply_below_threshold),
        .manual_reset_n         (manual_reset_n),
        .watchdog_input         (watchdog_input),
        .watchdog_input_driven  (watchdog_input_driven),
        .reset_out              (reset_out),
        .reset_out_n            (reset_out_n),
        .reset_od_out           (reset_od_out),
        .reset_od_oe_n          (reset_od_oe_n)
    );

    svwmr_cpu_model cpu (
        .clk                   (clk),
        .reset_line            (reset_line),
        .mode                  (cpu_mode),
        .period                (cpu_period),
        .watchdog_input        (watchdog_input),
        .watchdog_input_driven (watchdog_input_driven)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ======================================================================
    // Shared tasks
    // ======================================================================
    task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Counts falling edges until reset_out reaches lvl, giving up after hi.
    // Equal bounds ask that lvl is never reached; otherwise it must be reached.
    task automatic win(input logic lvl, input int lo, input int hi);
        int   k;
        logic ok;
        k = 0;
        while (reset_out !== lvl && k < hi) begin
            @(negedge clk);
            k++;
        end
        ok = (lo == hi) ? (reset_out !== lvl) : (k >= lo && reset_out === lvl);
        chk(ok, 32'(k), 32'(hi));
    endtask

    task automatic low_pulse_mr(input int n);
        manual_reset_n = 1'b0;
        repeat (n) @(negedge clk);
        manual_reset_n = 1'b1;
    endtask

    task automatic tally_and_finish();
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The pin levels must agree with reset_out on every cycle.
    always @(negedge clk) begin
        if (!rst) begin
            chk({reset_out_n, reset_od_oe_n, reset_od_out} === {~reset_out, ~reset_out, 1'b0},
                {29'h0, reset_out_n, reset_od_oe_n, reset_od_out},
                {29'h0, ~reset_out, ~reset_out, 1'b0});
        end
    end

    // ======================================================================
    // Scenarios
    // ======================================================================
    task automatic s_power_on();
        win(1'b0, RP - 1, RP + 6);
    endtask

    task automatic s_manual();
        low_pulse_mr(10);
        win(1'b1, 40, 40);
        manual_reset_n = 1'b0;
        win(1'b1, 0, 14);
        repeat (30) @(negedge clk);
        chk(reset_line === 1'b0, {31'h0, reset_line}, 32'h0);
        manual_reset_n = 1'b1;
        win(1'b0, RP - 1, RP + 6);
    endtask

    task automatic s_restart();
        low_pulse_mr(20);
        repeat (RP / 2) @(negedge clk);
        low_pulse_mr(20);
        chk(reset_out === 1'b1, {31'h0, reset_out}, 32'h1);
        win(1'b0, RP - 1, RP + 6);
    endtask

    task automatic s_supply();
        supply_below_threshold = 1'b1;
        repeat (20) @(negedge clk);
        supply_below_threshold = 1'b0;
        win(1'b1, 30, 30);
        supply_below_threshold = 1'b1;
        repeat (390) @(negedge clk);
        supply_below_threshold = 1'b0;
        win(1'b1, 30, 30);
        supply_below_threshold = 1'b1;
        win(1'b1, 0, 410);
        repeat (100) @(negedge clk);
        supply_below_threshold = 1'b0;
        win(1'b0, RP - 1, RP + 6);
    endtask

    task automatic s_watchdog();
        cpu_mode <= 2'h2;
        cpu_period <= 16'h0096;
        win(1'b1, 1000, 1000);
        cpu_mode <= 2'h1;
        cpu_period <= 16'h0032;
        win(1'b1, 1000, 1000);
        cpu_mode <= 2'h0;
        win(1'b1, WD - 52, WD + 6);
        win(1'b0, RP - 1, RP + 6);
        win(1'b1, WD - 2, WD + 6);
        win(1'b0, RP - 1, RP + 6);
    endtask

    task automatic s_float();
        cpu_mode <= 2'h3;
        win(1'b1, 5 * WD, 5 * WD);
        cpu_mode <= 2'h1;
    endtask

    // ======================================================================
    // Main sequence and watchdog of the run
    // ======================================================================
    initial begin
        err_count = 0;
        total_checks = 0;
        rst = 1'b1;
        supply_below_threshold = 1'b0;
        manual_reset_n = 1'b1;
        cpu_mode = 2'h1;
        cpu_period = 16'h0032;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        s_power_on();
        s_manual();
        s_restart();
        s_supply();
        s_watchdog();
        s_float();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule
